// file: src/plt_clkdiv.sv
// source select, synchronisers and two-stage down-counting divider
`timescale 1ns/1ps
`default_nettype none
`include "plt_params.svh"

module plt_clkdiv
   import plt_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [3:0] src_clk_in,
   plt_div_if.div         dif
);

   logic [3:0] s1_ff;
   logic [3:0] s2_ff;
   logic [3:0] s3_ff;
   logic [2:0] pre_cnt_ff;
   logic [2:0] ex_cnt_ff;
   logic [2:0] pre_m1;
   logic       src_edge;
   logic       pre_tick;

   ////////////////////////////////////////////////////////////////////////
   // every source is asynchronous: two flops, then a third for the edge
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               s1_ff[g] <= 1'b0;
               s2_ff[g] <= 1'b0;
               s3_ff[g] <= 1'b0;
            end else begin
               s1_ff[g] <= src_clk_in[g];
               s2_ff[g] <= s1_ff[g];
               s3_ff[g] <= s2_ff[g];
            end
         end
      end
   endgenerate

   assign src_edge = s2_ff[dif.src_sel] & ~s3_ff[dif.src_sel];

   always_comb begin
      case (dif.pre_sel)
         `PLT_PRE_DIV1: pre_m1 = 3'h0;
         `PLT_PRE_DIV2: pre_m1 = 3'h1;
         `PLT_PRE_DIV4: pre_m1 = 3'h3;
         `PLT_PRE_DIV8: pre_m1 = 3'h7;
         default:       pre_m1 = 3'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // zero state means the next source edge ticks at once
   assign pre_tick = dif.run & src_edge & (pre_cnt_ff == 3'h0);
   assign dif.tick = pre_tick & (ex_cnt_ff == 3'h0);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pre_cnt_ff <= `PLT_DIV_RST;
      end else if (dif.clear) begin
         pre_cnt_ff <= `PLT_DIV_RST;
      end else if (dif.run && src_edge) begin
         pre_cnt_ff <= (pre_cnt_ff == 3'h0) ? pre_m1 : pre_cnt_ff - 3'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ex_cnt_ff <= `PLT_DIV_RST;
      end else if (dif.clear) begin
         ex_cnt_ff <= `PLT_DIV_RST;
      end else if (pre_tick) begin
         ex_cnt_ff <= (ex_cnt_ff == 3'h0) ? dif.ex_sel : ex_cnt_ff - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_div_stopped: assert property (!dif.run |-> !dif.tick)
      else $error("divider ticked while stopped");
   a_div_first: assert property (dif.clear ##1 (dif.run
         && src_edge && !dif.clear) |-> dif.tick)
      else $error("first source edge after clear gave no tick");

endmodule

`default_nettype wire

// file: src/plt_core.sv
// programmable length timer counter core with modes and event flags
`timescale 1ns/1ps
`default_nettype none
`include "plt_params.svh"

// Notes on behaviour
// - count steps up or down on each divided timer clock tick
// - length 8, 10, 12 or 16 bits sets the maximum count
// - written count is right-aligned, unused upper bits forced to zero
// - timer clock picked from auxiliary, sub-main or two external clocks
// - first divider bypasses or divides by 2, 4 or 8
// - expansion divider code k divides by k plus one
// - divider is a down counter reset by the clear strobe
// - first tick on first source edge, then at the set ratio
// - clear zeroes count, divider state and direction; settings kept
// - after reset the timer is stopped with defaults everywhere
// - mode 00 stop, 01 up, 10 continuous, 11 up/down
// - continuous counts zero to length maximum, then wraps
// - up/down counts zero to period latch and back to zero; a period above the length maximum counts as continuous
// - up mode restarts at zero after the period latch value
// - entering up mode above the period latch restarts from zero
// - up mode sets compare flag on counting to period latch
// - up mode sets rollover flag on counting from period to zero
// - flags rise only from counting, never from direct writes
module plt_core
   import plt_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        aux_clk,
   input  wire logic        sub_main_clock,
   input  wire logic        external_clock_a,
   input  wire logic        external_clock_b,
   input  wire logic [1:0]  clk_source_sel,
   input  wire logic [1:0]  pre_divider_sel,
   input  wire logic [2:0]  expansion_divider_sel,
   input  wire logic [1:0]  count_length_sel,
   input  wire logic [1:0]  count_mode_sel,
   input  wire logic        counter_clear,
   input  wire logic        count_wr_en,
   input  wire logic [15:0] count_wr_data,
   input  wire logic [15:0] period_latch,
   input  wire logic        compare_flag_clr,
   input  wire logic        rollover_flag_clr,
   output logic      [15:0] count_value,
   output logic             count_dir_down,
   output logic             compare_event_flag,
   output logic             rollover_flag,
   output logic             timer_running
);

   ////////////////////////////////////////////////////////////////////////
   // length decode, used by the write path and the wrap logic
   function automatic logic [15:0] plt_len_max(input logic [1:0] len);
      case (plt_len_t'(len))
         PLT_L8:  plt_len_max = `PLT_MAX_8;
         PLT_L10: plt_len_max = `PLT_MAX_10;
         PLT_L12: plt_len_max = `PLT_MAX_12;
         PLT_L16: plt_len_max = `PLT_MAX_16;
         default: plt_len_max = `PLT_MAX_16;
      endcase
   endfunction

   plt_div_if   dif ();

   plt_mode_t   mode;
   plt_mode_t   mode_q_ff;
   logic [15:0] count_ff;
   logic        dir_down_ff;
   logic        cmp_flag_ff;
   logic        roll_flag_ff;
   logic [15:0] len_max;
   logic [15:0] nxt_count;
   logic        nxt_dir_down;
   logic        cmp_hit;
   logic        roll_hit;
   logic        run;
   logic        up_entry_fix;
   logic        step;
   logic        flag_ok;
   logic [15:0] count_inc;
   logic [15:0] count_dec;
   logic [15:0] wr_masked;

   ////////////////////////////////////////////////////////////////////////
   // divider hookup
   assign mode    = plt_mode_t'(count_mode_sel);
   assign run     = (mode != PLT_STOP);
   assign len_max = plt_len_max(count_length_sel);

   assign dif.run     = run;
   assign dif.clear   = counter_clear;
   assign dif.src_sel = clk_source_sel;
   assign dif.pre_sel = pre_divider_sel;
   assign dif.ex_sel  = expansion_divider_sel;

   plt_clkdiv plt_clkdiv_i (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .src_clk_in ({external_clock_b, sub_main_clock, aux_clk,
                    external_clock_a}),
      .dif        (dif.div)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode history, used to spot the entry into up mode
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode_q_ff <= PLT_STOP;
      end else begin
         mode_q_ff <= mode;
      end
   end

   // mode changes are expected to pass through stop first; a direct
   // jump from any other mode into up mode gets the same entry restart
   assign up_entry_fix = (mode == PLT_UP) && (mode_q_ff != PLT_UP)
                         && (count_ff > period_latch);

   // a write or clear in the same cycle overrides any counting step
   assign step    = run && dif.tick && !counter_clear && !count_wr_en
                    && !up_entry_fix;
   assign flag_ok = step;

   assign count_inc = count_ff + 16'h0001;
   assign count_dec = count_ff - 16'h0001;

   // shorter lengths keep only the low bits of a write
   assign wr_masked = count_wr_data & len_max;

   ////////////////////////////////////////////////////////////////////////
   // next count per mode
   always_comb begin
      nxt_count    = count_ff;
      nxt_dir_down = dir_down_ff;
      cmp_hit      = 1'b0;
      roll_hit     = 1'b0;
      case (mode)
         PLT_STOP: begin
            nxt_count = count_ff;
         end
         PLT_UP: begin
            if (count_ff >= period_latch) begin
               nxt_count = 16'h0000;
               roll_hit  = 1'b1;
            end else begin
               nxt_count = count_inc;
               cmp_hit   = (count_inc == period_latch);
            end
         end
         PLT_CONT: begin
            if (count_ff >= len_max) begin
               nxt_count = 16'h0000;
               roll_hit  = 1'b1;
            end else begin
               nxt_count = count_inc;
               cmp_hit   = (count_inc == period_latch);
            end
         end
         PLT_UPDN: begin
            if (period_latch > len_max) begin
               // period beyond the length: behaves as continuous
               if (count_ff >= len_max) begin
                  nxt_count = 16'h0000;
                  roll_hit  = 1'b1;
               end else begin
                  nxt_count = count_inc;
               end
            end else if (!dir_down_ff) begin
               if (count_ff >= period_latch && count_ff != 16'h0000) begin
                  nxt_count    = count_dec;
                  nxt_dir_down = 1'b1;
               end else if (count_ff < period_latch) begin
                  nxt_count = count_inc;
                  cmp_hit   = (count_inc == period_latch);
               end else begin
                  nxt_count = 16'h0000;
               end
            end else begin
               if (count_ff <= 16'h0001) begin
                  nxt_count    = 16'h0000;
                  nxt_dir_down = 1'b0;
                  roll_hit     = (count_ff == 16'h0001);
               end else begin
                  nxt_count = count_dec;
               end
            end
         end
         default: begin
            nxt_count = count_ff;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // count register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_ff <= `PLT_CNT_RST;
      end else if (counter_clear) begin
         count_ff <= 16'h0000;
      end else if (count_wr_en) begin
         count_ff <= wr_masked;
      end else if (up_entry_fix) begin
         count_ff <= 16'h0000;
      end else if (step) begin
         count_ff <= nxt_count;
      end
   end

   // direction survives stop, so a restart resumes the old direction
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dir_down_ff <= 1'b0;
      end else if (counter_clear) begin
         dir_down_ff <= 1'b0;
      end else if (step) begin
         dir_down_ff <= nxt_dir_down;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmp_flag_ff <= 1'b0;
      end else if (flag_ok && cmp_hit) begin
         cmp_flag_ff <= 1'b1;
      end else if (compare_flag_clr) begin
         cmp_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         roll_flag_ff <= 1'b0;
      end else if (flag_ok && roll_hit) begin
         roll_flag_ff <= 1'b1;
      end else if (rollover_flag_clr) begin
         roll_flag_ff <= 1'b0;
      end
   end

   assign count_value        = count_ff;
   assign count_dir_down     = dir_down_ff;
   assign compare_event_flag = cmp_flag_ff;
   assign rollover_flag      = roll_flag_ff;
   assign timer_running      = run;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_clear_zero: assert property (counter_clear |=>
         (count_value == 16'h0000) && !count_dir_down)
      else $error("clear did not zero count and direction");

   a_wr_masked: assert property ((count_wr_en && !counter_clear) |=>
         count_value == $past(wr_masked))
      else $error("written count not masked to length");

   a_stop_hold: assert property ((mode == PLT_STOP
         && !count_wr_en && !counter_clear) |=> $stable(count_value))
      else $error("count moved while stopped");

   a_up_wrap: assert property ((step && mode == PLT_UP
         && count_value == period_latch)
         |=> (count_value == 16'h0000) && rollover_flag)
      else $error("up mode did not wrap at period");

   a_up_cmp: assert property ((step && mode == PLT_UP
         && count_value < period_latch
         && count_inc == period_latch)
         |=> compare_event_flag && count_value == period_latch)
      else $error("compare flag missing at period");

   a_up_entry: assert property ((mode == PLT_UP
         && mode_q_ff == PLT_STOP && count_value > period_latch
         && !count_wr_en && !counter_clear) |=> count_value == 16'h0000)
      else $error("up entry above period did not restart");

   a_no_wr_flag: assert property ((!dif.tick) |=>
         !$rose(compare_event_flag) && !$rose(rollover_flag))
      else $error("flag rose without a timer tick");

   a_cont_wrap: assert property ((step && mode == PLT_CONT
         && count_value == len_max) |=> count_value == 16'h0000)
      else $error("continuous mode did not wrap at length maximum");

   a_updn_turn: assert property ((step && mode == PLT_UPDN
         && !count_dir_down && period_latch <= len_max
         && count_value == period_latch && count_value != 16'h0000)
         |=> count_dir_down ##0 count_value == $past(count_dec))
      else $error("up/down mode did not turn at period");

   a_step_once: assert property ((step && mode == PLT_CONT
         && count_value < len_max) |=> count_value == $past(count_inc))
      else $error("count did not step by one");

   // a tick lost to a write or an entry restart must stay silent
   a_wr_no_flag: assert property (count_wr_en |=>
         !$rose(compare_event_flag) && !$rose(rollover_flag))
      else $error("flag rose in a count write cycle");

   a_entry_quiet: assert property (up_entry_fix |=>
         !$rose(compare_event_flag) && !$rose(rollover_flag))
      else $error("up entry restart raised a flag");

   // direction is latched and only a step or a clear may move it
   a_dir_hold: assert property ((!step && !counter_clear) |=>
         $stable(count_dir_down))
      else $error("direction changed without a step");

   a_updn_floor: assert property ((step && mode == PLT_UPDN
         && count_dir_down && period_latch <= len_max
         && count_value == 16'h0001)
         |=> (count_value == 16'h0000) && !count_dir_down && rollover_flag)
      else $error("up/down mode did not turn at zero");

   a_len_bound: assert property ((step && mode == PLT_CONT
         && count_value <= len_max) |=> count_value <= len_max)
      else $error("continuous count left the length range");

   a_up_bound: assert property ((step && mode == PLT_UP
         && count_value <= period_latch)
         |=> count_value <= $past(period_latch))
      else $error("up count passed the period");

   c_up_wrap: cover property (step && mode == PLT_UP
         && count_value == period_latch ##1 rollover_flag);
   c_updn_turn: cover property (step && mode == PLT_UPDN
         && !count_dir_down ##1 count_dir_down);
   c_cont_wrap: cover property (step && mode == PLT_CONT
         && count_value == len_max);
   c_clear_run: cover property (counter_clear ##1 run && dif.tick);
   c_up_entry: cover property (up_entry_fix ##1 count_value == 16'h0000);

endmodule

`default_nettype wire

// file: src/plt_div_if.sv
// carrier between the counter core and its clock divider
`timescale 1ns/1ps
`default_nettype none

interface plt_div_if;
   logic       run;
   logic       clear;
   logic [1:0] src_sel;
   logic [1:0] pre_sel;
   logic [2:0] ex_sel;
   logic       tick;

   modport core (output run, output clear, output src_sel, output pre_sel,
                 output ex_sel, input tick);
   modport div  (input run, input clear, input src_sel, input pre_sel,
                 input ex_sel, output tick);
endinterface

`default_nettype wire

// file: src/plt_div_if_unused_guard.sv
// empty unit beside the divider carrier; holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: src/plt_params.svh
// constants of the programmable length timer core
`ifndef PLT_PARAMS_SVH
`define PLT_PARAMS_SVH

`define PLT_CNT_W      16
`define PLT_CNT_RST    16'h0000
`define PLT_MAX_8      16'h00ff
`define PLT_MAX_10     16'h03ff
`define PLT_MAX_12     16'h0fff
`define PLT_MAX_16     16'hffff
`define PLT_LEN_8      2'h0
`define PLT_LEN_10     2'h1
`define PLT_LEN_12     2'h2
`define PLT_LEN_16     2'h3
`define PLT_MODE_STOP  2'h0
`define PLT_MODE_UP    2'h1
`define PLT_MODE_CONT  2'h2
`define PLT_MODE_UPDN  2'h3
`define PLT_SRC_EXT_A  2'h0
`define PLT_SRC_AUX    2'h1
`define PLT_SRC_SUBM   2'h2
`define PLT_SRC_EXT_B  2'h3
`define PLT_PRE_DIV1   2'h0
`define PLT_PRE_DIV2   2'h1
`define PLT_PRE_DIV4   2'h2
`define PLT_PRE_DIV8   2'h3
`define PLT_DIV_RST    3'h0

`endif

// file: src/plt_pkg.sv
// types of the programmable length timer core
`include "plt_params.svh"

package plt_pkg;

   typedef enum logic [1:0] {
      PLT_STOP = `PLT_MODE_STOP,
      PLT_UP   = `PLT_MODE_UP,
      PLT_CONT = `PLT_MODE_CONT,
      PLT_UPDN = `PLT_MODE_UPDN
   } plt_mode_t;

   typedef enum logic [1:0] {
      PLT_L8  = `PLT_LEN_8,
      PLT_L10 = `PLT_LEN_10,
      PLT_L12 = `PLT_LEN_12,
      PLT_L16 = `PLT_LEN_16
   } plt_len_t;

endpackage

// file: verification/plt_core_test.sv
// self-checking bench for the programmable length timer core
`timescale 1ns/1ps
`default_nettype none
`include "plt_params.svh"

module plt_core_test
   import plt_pkg::*;
;

   logic        ref_clk;
   logic        rst;
   logic [3:0]  src;
   logic [1:0]  clk_source_sel;
   logic [1:0]  pre_divider_sel;
   logic [2:0]  expansion_divider_sel;
   logic [1:0]  count_length_sel;
   logic [1:0]  count_mode_sel;
   logic        counter_clear;
   logic        count_wr_en;
   logic [15:0] count_wr_data;
   logic [15:0] period_latch;
   logic        compare_flag_clr;
   logic        rollover_flag_clr;
   logic [15:0] count_value;
   logic        count_dir_down;
   logic        compare_event_flag;
   logic        rollover_flag;
   logic        timer_running;
   int          errors;
   int          checked;
   logic [15:0] maxv [4] = '{`PLT_MAX_8, `PLT_MAX_10, `PLT_MAX_12,
                             `PLT_MAX_16};
   logic [1:0]  pre_tab [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
   logic [2:0]  ex_tab [4] = '{3'h1, 3'h7, 3'h0, 3'h0};
   int          ratio_tab [4] = '{4, 8, 4, 8};

   ////////////////////////////////////////////////////////////////////////////
   // src index follows the select encoding: ext a, aux, sub-main, ext b
   plt_core plt_core_i (
      .ref_clk               (ref_clk),
      .rst                   (rst),
      .aux_clk               (src[1]),
      .sub_main_clock        (src[2]),
      .external_clock_a      (src[0]),
      .external_clock_b      (src[3]),
      .clk_source_sel        (clk_source_sel),
      .pre_divider_sel       (pre_divider_sel),
      .expansion_divider_sel (expansion_divider_sel),
      .count_length_sel      (count_length_sel),
      .count_mode_sel        (count_mode_sel),
      .counter_clear         (counter_clear),
      .count_wr_en           (count_wr_en),
      .count_wr_data         (count_wr_data),
      .period_latch          (period_latch),
      .compare_flag_clr      (compare_flag_clr),
      .rollover_flag_clr     (rollover_flag_clr),
      .count_value           (count_value),
      .count_dir_down        (count_dir_down),
      .compare_event_flag    (compare_event_flag),
      .rollover_flag         (rollover_flag),
      .timer_running         (timer_running)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic step(int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk_cnt(logic [15:0] exp);
      checked++;
      if (count_value !== exp) begin
         errors++;
         $display("[ERR] %0t count %h expected %h", $time, count_value, exp);
      end
   endtask

   task automatic chk_bit(logic got, logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t status bit %b expected %b", $time, got, exp);
      end
   endtask

   // slow source edges: 4 ref cycles high and low keep the synchroniser safe
   task automatic edges(int n, int idx);
      repeat (n) begin
         src[idx] = 1'b1;
         step(4);
         src[idx] = 1'b0;
         step(4);
      end
      step(4);
   endtask

   task automatic wr(logic [15:0] d);
      count_wr_data = d;
      count_wr_en   = 1'b1;
      step();
      count_wr_en   = 1'b0;
      step();
   endtask

   task automatic clr();
      counter_clear = 1'b1;
      step();
      counter_clear = 1'b0;
   endtask

   task automatic fclr();
      compare_flag_clr  = 1'b1;
      rollover_flag_clr = 1'b1;
      step();
      compare_flag_clr  = 1'b0;
      rollover_flag_clr = 1'b0;
   endtask

   // every mode change passes through stop first
   task automatic mode(logic [1:0] m);
      count_mode_sel = PLT_STOP;
      step();
      count_mode_sel = m;
      step(2);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      errors = 0;
      checked = 0;
      rst = 1'b1;
      src = 4'h0;
      clk_source_sel = 2'h0;
      pre_divider_sel = 2'h0;
      expansion_divider_sel = 3'h0;
      count_length_sel = PLT_L16;
      count_mode_sel = PLT_STOP;
      counter_clear = 1'b0;
      count_wr_en = 1'b0;
      count_wr_data = 16'h0000;
      period_latch = 16'h0000;
      compare_flag_clr = 1'b0;
      rollover_flag_clr = 1'b0;
      step(4);
      rst = 1'b0;
      step(3);
      chk_cnt(16'h0000);
      chk_bit(count_dir_down, 1'b0);
      chk_bit(compare_event_flag | rollover_flag, 1'b0);
      chk_bit(timer_running, 1'b0);
      for (int i = 0; i < 4; i++) begin
         count_length_sel = 2'(i);
         wr(16'hffff);
         chk_cnt(maxv[i]);
      end
      count_length_sel = PLT_L8;
      wr(16'h1234);
      chk_cnt(16'h0034);
      period_latch = 16'h0034;
      wr(16'h0034);
      chk_bit(compare_event_flag, 1'b0);
      edges(3, 0);
      chk_cnt(16'h0034);
      wr(16'h00fe);
      mode(PLT_CONT);
      chk_bit(timer_running, 1'b1);
      edges(1, 0);
      chk_cnt(16'h00ff);
      edges(1, 0);
      chk_cnt(16'h0000);
      chk_bit(rollover_flag, 1'b1);
      chk_bit(compare_event_flag, 1'b0);
      // up mode, period 2
      mode(PLT_STOP);
      count_length_sel = PLT_L16;
      clr();
      period_latch = 16'h0002;
      fclr();
      mode(PLT_UP);
      edges(1, 0);
      chk_cnt(16'h0001);
      edges(1, 0);
      chk_cnt(16'h0002);
      chk_bit(compare_event_flag, 1'b1);
      chk_bit(rollover_flag, 1'b0);
      edges(1, 0);
      chk_cnt(16'h0000);
      chk_bit(rollover_flag, 1'b1);
      mode(PLT_STOP);
      wr(16'h0009);
      fclr();
      mode(PLT_UP);
      chk_cnt(16'h0000);
      chk_bit(compare_event_flag | rollover_flag, 1'b0);
      // up/down, period 3
      mode(PLT_STOP);
      period_latch = 16'h0003;
      clr();
      fclr();
      mode(PLT_UPDN);
      edges(3, 0);
      chk_cnt(16'h0003);
      chk_bit(compare_event_flag, 1'b1);
      edges(1, 0);
      chk_cnt(16'h0002);
      chk_bit(count_dir_down, 1'b1);
      edges(2, 0);
      chk_cnt(16'h0000);
      chk_bit(rollover_flag, 1'b1);
      // stop while counting down so the clear has a direction to reset
      edges(4, 0);
      chk_bit(count_dir_down, 1'b1);
      mode(PLT_STOP);
      clr();
      chk_cnt(16'h0000);
      chk_bit(count_dir_down, 1'b0);
      // dividers: /2 and /2 gives 4, bypass and code 7 gives 8, /4, /8
      for (int j = 0; j < 4; j++) begin
         mode(PLT_STOP);
         pre_divider_sel = pre_tab[j];
         expansion_divider_sel = ex_tab[j];
         clr();
         mode(PLT_CONT);
         edges(1, 0);
         chk_cnt(16'h0001);
         edges(ratio_tab[j] - 1, 0);
         chk_cnt(16'h0001);
         edges(1, 0);
         chk_cnt(16'h0002);
      end
      // sources: an unselected clock must not step the count
      mode(PLT_STOP);
      pre_divider_sel = 2'h0;
      expansion_divider_sel = 3'h0;
      clr();
      mode(PLT_CONT);
      for (int s = 0; s < 4; s++) begin
         clk_source_sel = 2'(s);
         step(2);
         edges(1, (s + 1) % 4);
         chk_cnt(16'(s));
         edges(1, s);
         chk_cnt(16'(s + 1));
      end
      wrap_up();
   end

   // whole run is well under 2000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end

endmodule

`default_nettype wire
